// ===== serial_link_irq_status.sv
/*
  Status and interrupt aggregation for a multi-lane serial receive link.
  Assumes a byte-wide register port in the mclk domain and link status on asynchronous wires.
*/
// Notes on behaviour
// - checksum bit per lane: 1 good, 0 bad
// - write 1 to bit 7 clears checksum interrupt
// - initial sync bits, bit 7 clears, vector bit 3
// - lost sync also raises sync request output when test mode bit 7 is clear
// - octets per frame only 1, 2, 4; reset 1
// - test mode bit 7 keeps accepting alignment frames
// - multiframe count is frames over four, reset 1
// - disparity enable plus threshold hit pulls irq low
// - not-in-table enable plus hit pulls irq low
// - unexpected control enable plus hit pulls irq low
// - initial sync enable plus failure pulls irq low
// - checksum enable plus bad checksum pulls irq low
// - frame sync enable plus failure pulls irq low
// - code group enable plus failure pulls irq low
// - per-lane error bit sets at common threshold
`timescale 1ns/1ps
module serial_link_irq_status
  import link_irq_pkg::*;
#(
  parameter int NLANES = LANES
)(
  input  wire logic                mclk,
  input  wire logic                rstn,
  input  wire logic                clk_en,
  input  wire reg_req_t            reg_req,
  output      logic [DATA_W-1:0]   reg_rdata,
  output      logic                reg_rvalid,
  input  wire lane_status_t        lane_status,
  input  wire lane_errors_t        lane_errors,
  input  wire logic [2:0]          sync_request_mask,
  output      logic                irq_n,
  output      logic                sync_request_out,
  output      logic [DATA_W-1:0]   octets_per_frame,
  output      logic                alignment_test_mode,
  output      logic                threshold_mask_enable,
  output      logic [DATA_W-1:0]   alignment_multiframes_div4,
  output      logic [DATA_W-1:0]   error_clear_lanes
);

  // reset release through two flops
  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // all link-side status crosses into mclk first
  localparam int SYNC_W = 7 * NLANES;

  // good levels idle high; they cross inverted so the all-zero synchroniser reset
  // does not read as a failure on every lane and latch false sticky flags
  localparam logic [SYNC_W-1:0] GOOD_FLIP = {{(4 * NLANES){1'b1}}, {(3 * NLANES){1'b0}}};

  logic [SYNC_W-1:0] raw_all;
  logic [SYNC_W-1:0] syn_all;

  assign raw_all = GOOD_FLIP ^ {lane_status.chksum_ok, lane_status.init_sync, lane_status.frame_sync,
                                lane_status.code_group, lane_errors.disparity, lane_errors.not_in_table,
                                lane_errors.unexpected};

  status_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .ce       (clk_en),
    .async_in (raw_all),
    .sync_out (syn_all)
  );

  logic [NLANES-1:0] chk_live;
  logic [NLANES-1:0] init_live;
  logic [NLANES-1:0] frame_live;
  logic [NLANES-1:0] code_live;
  logic [NLANES-1:0] disp_live;
  logic [NLANES-1:0] nit_live;
  logic [NLANES-1:0] ucc_live;

  assign {chk_live, init_live, frame_live, code_live, disp_live, nit_live, ucc_live} = GOOD_FLIP ^ syn_all;

  // register write decode
  logic wr_chk;
  logic wr_init;
  logic wr_oct;
  logic wr_test;
  logic wr_k;
  logic wr_vec;
  logic clr_chk;
  logic clr_init;

  assign wr_chk   = clk_en && reg_req.wr && (reg_req.addr == OFS_CHKSUM);
  assign wr_init  = clk_en && reg_req.wr && (reg_req.addr == OFS_INITSYNC);
  assign wr_oct   = clk_en && reg_req.wr && (reg_req.addr == OFS_OCTETS);
  assign wr_test  = clk_en && reg_req.wr && (reg_req.addr == OFS_TESTCTL);
  assign wr_k     = clk_en && reg_req.wr && (reg_req.addr == OFS_KCOUNT);
  assign wr_vec   = clk_en && reg_req.wr && (reg_req.addr == OFS_IRQVEC);
  assign clr_chk  = wr_chk && reg_req.wdata[BIT_IRQ_RST];
  assign clr_init = wr_init && reg_req.wdata[BIT_IRQ_RST];

  // failure records, sticky for checksum and initial sync only; a failure is a lane reading 0
  logic [NLANES-1:0] chk_fail_q;
  logic [NLANES-1:0] init_fail_q;
  logic [NLANES-1:0] frame_fail_q;
  logic [NLANES-1:0] code_fail_q;
  logic              chk_any;
  logic              init_any;
  logic              frame_any;
  logic              code_any;

  sticky_lane_flags #(
    .WIDTH (NLANES)
  ) u_chk_flags (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .ce     (clk_en),
    .fail   (~chk_live),
    .clear  (clr_chk),
    .flag_q (chk_fail_q),
    .any_q  (chk_any)
  );

  sticky_lane_flags #(
    .WIDTH (NLANES)
  ) u_init_flags (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .ce     (clk_en),
    .fail   (~init_live),
    .clear  (clr_init),
    .flag_q (init_fail_q),
    .any_q  (init_any)
  );

  // frame and code group flags have no clear port in this block; they follow the live state
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frame_fail_q <= '0;
      code_fail_q  <= '0;
      frame_any    <= 1'b0;
      code_any     <= 1'b0;
    end
    else if (clk_en)
    begin
      frame_fail_q <= ~frame_live;
      code_fail_q  <= ~code_live;
      frame_any    <= |(~frame_live);
      code_any     <= |(~code_live);
    end
  end

  // per-lane threshold hits; counters live upstream
  logic [NLANES-1:0] disp_hit_q;
  logic [NLANES-1:0] nit_hit_q;
  logic [NLANES-1:0] ucc_hit_q;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      disp_hit_q <= '0;
      nit_hit_q  <= '0;
      ucc_hit_q  <= '0;
    end
    else if (clk_en)
    begin
      disp_hit_q <= disp_live;
      nit_hit_q  <= nit_live;
      ucc_hit_q  <= ucc_live;
    end
  end

  // configuration registers
  logic [DATA_W-1:0] oct_q;
  logic [DATA_W-1:0] test_q;
  logic [DATA_W-1:0] k_q;
  logic [DATA_W-1:0] mask_q;

  // octets per frame: illegal values are ignored, keeps last legal
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      oct_q <= RST_OCTETS;
    else if (wr_oct && (reg_req.wdata == OCTETS_ONE || reg_req.wdata == OCTETS_TWO ||
                        reg_req.wdata == OCTETS_FOUR))
      oct_q <= reg_req.wdata;
  end

  // test control keeps only its two live bits
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      test_q <= RST_TESTCTL;
    else if (wr_test)
      test_q <= reg_req.wdata & TESTCTL_USED;
  end

  // zero would stall the alignment sequence, so a zero write is dropped
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      k_q <= RST_KCOUNT;
    else if (wr_k && (reg_req.wdata != '0))
      k_q <= reg_req.wdata;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      mask_q <= RST_MASK;
    else if (wr_vec)
      mask_q <= reg_req.wdata & VEC_USED;
  end

  // per-class summary vector
  logic [DATA_W-1:0] vec;

  always_comb
  begin
    vec                   = '0;
    vec[BIT_VEC_DISP]     = |disp_hit_q;
    vec[BIT_VEC_NIT]      = |nit_hit_q;
    vec[BIT_VEC_UCC]      = |ucc_hit_q;
    vec[BIT_VEC_INITSYNC] = init_any;
    vec[BIT_VEC_CHKSUM]   = chk_any;
    vec[BIT_VEC_FRAME]    = frame_any;
    vec[BIT_VEC_CODEGRP]  = code_any;
  end

  // interrupt low while any enabled source is latched
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      irq_n <= 1'b1;
    else if (clk_en)
      irq_n <= ~|(vec & mask_q);
  end

  // sync request on lost sync outside test mode or on masked threshold classes
  logic thr_req;

  assign thr_req = test_q[BIT_THRESH_EN] && |(sync_request_mask & {|disp_hit_q, |nit_hit_q, |ucc_hit_q});

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      sync_request_out <= 1'b0;
    else if (clk_en)
      sync_request_out <= (|(~init_live) && !test_q[BIT_TEST_MODE]) || thr_req;
  end

  // lanes in error, offered to the counter bank
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      error_clear_lanes <= '0;
    else if (clk_en)
      error_clear_lanes <= disp_hit_q | nit_hit_q | ucc_hit_q;
  end

  // configuration outputs from flops
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      octets_per_frame           <= RST_OCTETS;
      alignment_test_mode        <= 1'b0;
      threshold_mask_enable      <= 1'b0;
      alignment_multiframes_div4 <= RST_KCOUNT;
    end
    else if (clk_en)
    begin
      octets_per_frame           <= oct_q;
      alignment_test_mode        <= test_q[BIT_TEST_MODE];
      threshold_mask_enable      <= test_q[BIT_THRESH_EN];
      alignment_multiframes_div4 <= k_q;
    end
  end

  // read mux; status registers show live good bits
  logic [DATA_W-1:0] rd_mux;

  always_comb
  begin
    case (reg_req.addr)
      OFS_CHKSUM:   rd_mux = chk_live;
      OFS_INITSYNC: rd_mux = init_live;
      OFS_OCTETS:   rd_mux = oct_q;
      OFS_TESTCTL:  rd_mux = test_q;
      OFS_KCOUNT:   rd_mux = k_q;
      OFS_IRQVEC:   rd_mux = vec;
      default:      rd_mux = '0;
    endcase
  end

  // read data one cycle after the strobe
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata  <= '0;
      reg_rvalid <= 1'b0;
    end
    else if (clk_en)
    begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd)
        reg_rdata <= rd_mux;
    end
  end

endmodule : serial_link_irq_status

// ===== link_irq_pkg.sv
/*
  Shared constants and carrier types for the serial link status and interrupt block.
  Assumes an 8-bit register port with a small byte address, one clock mclk.
*/
package link_irq_pkg;

  localparam int          LANES        = 8;
  localparam int          ADDR_W       = 12;
  localparam int          DATA_W       = 8;

  // register offsets
  localparam logic [11:0] OFS_CHKSUM   = 12'h472;
  localparam logic [11:0] OFS_INITSYNC = 12'h473;
  localparam logic [11:0] OFS_OCTETS   = 12'h476;
  localparam logic [11:0] OFS_TESTCTL  = 12'h477;
  localparam logic [11:0] OFS_KCOUNT   = 12'h478;
  localparam logic [11:0] OFS_IRQVEC   = 12'h47a;

  // field positions
  localparam int          BIT_IRQ_RST      = 7;
  localparam int          BIT_TEST_MODE    = 7;
  localparam int          BIT_THRESH_EN    = 3;
  localparam int          BIT_VEC_DISP     = 7;
  localparam int          BIT_VEC_NIT      = 6;
  localparam int          BIT_VEC_UCC      = 5;
  localparam int          BIT_VEC_INITSYNC = 3;
  localparam int          BIT_VEC_CHKSUM   = 2;
  localparam int          BIT_VEC_FRAME    = 1;
  localparam int          BIT_VEC_CODEGRP  = 0;

  // reset values, legal octet settings and used-bit masks
  localparam logic [7:0]  RST_OCTETS   = 8'h01;
  localparam logic [7:0]  RST_TESTCTL  = 8'h00;
  localparam logic [7:0]  RST_KCOUNT   = 8'h01;
  localparam logic [7:0]  RST_MASK     = 8'h00;
  localparam logic [7:0]  OCTETS_ONE   = 8'h01;
  localparam logic [7:0]  OCTETS_TWO   = 8'h02;
  localparam logic [7:0]  OCTETS_FOUR  = 8'h04;
  localparam logic [7:0]  VEC_USED     = 8'hef;
  localparam logic [7:0]  TESTCTL_USED = 8'h88;

  localparam int          STAGE_CNT    = 3;

  // per-lane live status from the link layer
  typedef struct packed {
    logic [LANES-1:0] chksum_ok;
    logic [LANES-1:0] init_sync;
    logic [LANES-1:0] frame_sync;
    logic [LANES-1:0] code_group;
  } lane_status_t;

  // per-lane threshold hits from the error counters
  typedef struct packed {
    logic [LANES-1:0] disparity;
    logic [LANES-1:0] not_in_table;
    logic [LANES-1:0] unexpected;
  } lane_errors_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

endpackage : link_irq_pkg

// ===== status_sync.sv
/*
  Three-stage synchroniser bank with agreement filter.
  Assumes inputs come from the link domain, unrelated to mclk.
*/
`timescale 1ns/1ps
module status_sync
  import link_irq_pkg::*;
#(
  parameter int WIDTH = 8
)(
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] async_in,
  output      logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  // first stage feeds only the second
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else if (ce)
    begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a bit only moves once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
          sync_out[i] <= 1'b0;
        else if (ce && (s2_q[i] == s3_q[i]))
          sync_out[i] <= s3_q[i];
      end
    end
  endgenerate

endmodule : status_sync

// ===== sticky_lane_flags.sv
/*
  Per-lane sticky failure flags for one error class.
  Assumes fail inputs are already in the mclk domain; clear is a one-cycle strobe.
*/
`timescale 1ns/1ps
module sticky_lane_flags
  import link_irq_pkg::*;
#(
  parameter int WIDTH = 8
)(
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] fail,
  input  wire logic             clear,
  output      logic [WIDTH-1:0] flag_q,
  output      logic             any_q
);

  logic [WIDTH-1:0] flag_d;

  // a failure in the clear cycle survives the clear
  always_comb
  begin
    flag_d = (clear ? '0 : flag_q) | fail;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_q <= '0;
      any_q  <= 1'b0;
    end
    else if (ce)
    begin
      flag_q <= flag_d;
      any_q  <= |flag_d;
    end
  end

endmodule : sticky_lane_flags

// ===== link_partner.sv
/*
  Model of the far-end transmitter as seen through the per-lane status and error levels.
  Assumes the bench moves the fault controls just after a clock edge.
*/
`timescale 1ns/1ps
module link_partner
  import link_irq_pkg::*;
(
  input  wire logic [2:0] fault_cls,
  input  wire logic [2:0] fault_lane,
  input  wire logic       fault_on,
  output      lane_status_t lane_status,
  output      lane_errors_t lane_errors
);
  // one lane of one class goes wrong at a time, the rest stay healthy
  function automatic logic [LANES-1:0] hit(input logic [2:0] c);
    return (fault_on && fault_cls == c) ? (8'h01 << fault_lane) : 8'h00;
  endfunction : hit

  // good levels idle high, threshold hits idle low
  always_comb
  begin
    lane_errors.disparity    = hit(3'd0);
    lane_errors.not_in_table = hit(3'd1);
    lane_errors.unexpected   = hit(3'd2);
    lane_status.init_sync    = ~hit(3'd3);
    lane_status.chksum_ok    = ~hit(3'd4);
    lane_status.frame_sync   = ~hit(3'd5);
    lane_status.code_group   = ~hit(3'd6);
  end
endmodule : link_partner

// ===== serial_link_irq_status_checker.sv
/*
  Concurrent checks on the status and interrupt block ports.
  Assumes a single clock mclk and the asynchronous active-low rstn.
*/
`timescale 1ns/1ps
module serial_link_irq_status_checker
  import link_irq_pkg::*;
#(
  parameter int NLANES = LANES
)(
  input wire logic              mclk,
  input wire logic              rstn,
  input wire logic              clk_en,
  input wire reg_req_t          reg_req,
  input wire logic              reg_rvalid,
  input wire lane_status_t      lane_status,
  input wire lane_errors_t      lane_errors,
  input wire logic              irq_n,
  input wire logic              sync_request_out,
  input wire logic [DATA_W-1:0] octets_per_frame,
  input wire logic              alignment_test_mode,
  input wire logic              threshold_mask_enable,
  input wire logic [DATA_W-1:0] alignment_multiframes_div4
);
  logic [7:0] mask_q;
  logic       wr_ok;
  logic       oct_ok;

  assign wr_ok  = clk_en && reg_req.wr;
  assign oct_ok = reg_req.wdata inside {OCTETS_ONE, OCTETS_TWO, OCTETS_FOUR};

  // shadow of the enables, which read back as the vector instead
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      mask_q <= RST_MASK;
    else if (wr_ok && reg_req.addr == OFS_IRQVEC)
      mask_q <= reg_req.wdata & VEC_USED;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  // a held cause must show on irq within the synchroniser latency
  property class_irq(en, bad);
    (en && clk_en && bad)[*8] |-> ##[0:4] !irq_n;
  endproperty

  octets_legal_a: assert property (octets_per_frame inside {8'h01, 8'h02, 8'h04})
    else $error("octets setting outside 1, 2, 4");
  // config outputs trail the register by one flop, so writes show two edges later
  octets_write_a: assert property (wr_ok && reg_req.addr == OFS_OCTETS |-> ##2
    octets_per_frame == ($past(oct_ok, 2) ? $past(reg_req.wdata, 2) : $past(octets_per_frame)))
    else $error("octets write handled wrongly");
  kcount_write_a: assert property (wr_ok && reg_req.addr == OFS_KCOUNT |-> ##2
    alignment_multiframes_div4 == ($past(reg_req.wdata, 2) != 8'h00 ? $past(reg_req.wdata, 2) :
    $past(alignment_multiframes_div4)))
    else $error("multiframe count write handled wrongly");
  test_mode_a: assert property (wr_ok && reg_req.addr == OFS_TESTCTL |-> ##2
    alignment_test_mode == $past(reg_req.wdata[7], 2) && threshold_mask_enable == $past(reg_req.wdata[3], 2))
    else $error("test control bits not taken");
  disparity_irq_a: assert property (class_irq(mask_q[7], |lane_errors.disparity))
    else $error("disparity hit did not pull irq low");
  checksum_irq_a: assert property (class_irq(mask_q[2], ~&lane_status.chksum_ok))
    else $error("bad checksum did not pull irq low");
  code_group_irq_a: assert property (class_irq(mask_q[0], ~&lane_status.code_group))
    else $error("code group loss did not pull irq low");
  sync_req_a: assert property ((!alignment_test_mode && clk_en && ~&lane_status.init_sync)[*8]
    |-> ##[0:4] sync_request_out) else $error("lost sync not requested");
  irq_idle_a: assert property ((mask_q == 8'h00 && clk_en)[*3] |-> irq_n)
    else $error("irq low with every source disabled");
  read_answer_a: assert property (clk_en && reg_req.rd |=> reg_rvalid)
    else $error("read not answered");

  irq_seen_c: cover property (!irq_n ##1 irq_n);
  sync_seen_c: cover property (!sync_request_out ##1 sync_request_out);
  test_mode_c: cover property (alignment_test_mode && ~&lane_status.init_sync);
endmodule : serial_link_irq_status_checker

bind serial_link_irq_status serial_link_irq_status_checker #(.NLANES(NLANES)) u_chk (
  .mclk(mclk), .rstn(rstn), .clk_en(clk_en), .reg_req(reg_req), .reg_rvalid(reg_rvalid),
  .lane_status(lane_status), .lane_errors(lane_errors), .irq_n(irq_n),
  .sync_request_out(sync_request_out), .octets_per_frame(octets_per_frame),
  .alignment_test_mode(alignment_test_mode), .threshold_mask_enable(threshold_mask_enable),
  .alignment_multiframes_div4(alignment_multiframes_div4));

// ===== serial_link_irq_status_tb.sv
/*
  Self-checking bench for the link status and interrupt block.
  Assumes the partner model and the bound checker compile alongside.
*/
`timescale 1ns/1ps
module serial_link_irq_status_tb
  import link_irq_pkg::*;
;
  logic         mclk = 1'b0;
  logic         rstn = 1'b0;
  reg_req_t     req = '0;
  logic [2:0]   f_cls = 3'd0;
  logic [2:0]   smask = 3'b000;
  logic [2:0]   f_lane = 3'd0;
  logic         f_on = 1'b0;
  lane_status_t ls;
  lane_errors_t le;
  logic [7:0]   rdata, octets, kdiv, eclr;
  logic         rvalid, irq_n, sreq, tmode, thr_en;
  logic [7:0]   sizes [3] = '{OCTETS_ONE, OCTETS_TWO, OCTETS_FOUR};
  int           err_count = 0;
  int           samples_checked = 0;
  int           cycles = 0;

  always #4 mclk = ~mclk;

  serial_link_irq_status u_dut (
    .mclk(mclk), .rstn(rstn), .clk_en(1'b1), .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid),
    .lane_status(ls), .lane_errors(le), .sync_request_mask(smask), .irq_n(irq_n),
    .sync_request_out(sreq), .octets_per_frame(octets), .alignment_test_mode(tmode),
    .threshold_mask_enable(thr_en), .alignment_multiframes_div4(kdiv), .error_clear_lanes(eclr));

  link_partner u_tx (
    .fault_cls(f_cls), .fault_lane(f_lane), .fault_on(f_on), .lane_status(ls), .lane_errors(le));

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    req <= '0;
  endtask : wr

  // answer lands on the taking edge, checked 1 ns after it
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge mclk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk);
    req <= '0;
    #1;
    chk("rvalid", 8'h01, {7'h0, rvalid});
    chk("rdata", exp, rdata);
  endtask : rd

  // fixed settle covers the synchroniser and registered irq
  task automatic fault(input logic [2:0] c, input logic on);
    @(posedge mclk);
    f_cls <= c;
    f_lane <= 3'($urandom_range(7));
    f_on <= on;
    repeat (12) @(posedge mclk);
  endtask : fault

  // vector position of each class, bit 4 skipped
  function automatic logic [7:0] vbit(input int c);
    return 8'h80 >> (c < 3 ? c : c + 1);
  endfunction : vbit

  // hang guard, well above the expected run length
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      err_count++;
      close_out();
    end
  end

  initial
  begin
    logic [7:0] d;
    void'($urandom(32'hadade5b6));
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    repeat (8) @(posedge mclk);
    rd(OFS_OCTETS, RST_OCTETS);
    rd(OFS_KCOUNT, RST_KCOUNT);
    rd(OFS_TESTCTL, RST_TESTCTL);
    rd(OFS_CHKSUM, 8'hff);
    rd(OFS_INITSYNC, 8'hff);
    rd(OFS_IRQVEC, 8'h00);
    rd(12'h47f, 8'h00);
    // each legal size, then a random illegal value that must bounce
    foreach (sizes[i])
    begin
      d = 8'($urandom);
      if (d inside {8'h01, 8'h02, 8'h04})
        d = 8'h00;
      wr(OFS_OCTETS, sizes[i]);
      wr(OFS_OCTETS, d);
      rd(OFS_OCTETS, sizes[i]);
      chk("octets", sizes[i], octets);
    end
    d = 8'($urandom_range(255, 1));
    wr(OFS_KCOUNT, d);
    wr(OFS_KCOUNT, 8'h00);
    rd(OFS_KCOUNT, d);
    chk("kdiv", d, kdiv);
    // reserved bits must read back zero
    wr(OFS_TESTCTL, 8'hff);
    rd(OFS_TESTCTL, TESTCTL_USED);
    chk("tmode", 8'h01, {7'h0, tmode});
    chk("thr_en", 8'h01, {7'h0, thr_en});
    fault(3'd3, 1'b1);
    chk("sreq_test", 8'h00, {7'h0, sreq});
    wr(OFS_TESTCTL, 8'h00);
    repeat (12) @(posedge mclk);
    chk("sreq", 8'h01, {7'h0, sreq});
    fault(3'd3, 1'b0);
    wr(OFS_INITSYNC, 8'h80);
    // per class: disabled stays quiet, enabled pulls low, then recovery
    for (int c = 0; c < 7; c++)
    begin
      wr(OFS_IRQVEC, VEC_USED & ~vbit(c));
      fault(3'(c), 1'b1);
      chk("irq_off", 8'h01, {7'h0, irq_n});
      wr(OFS_IRQVEC, vbit(c));
      repeat (4) @(posedge mclk);
      chk("irq_on", 8'h00, {7'h0, irq_n});
      rd(OFS_IRQVEC, vbit(c));
      if (c == 4)
        rd(OFS_CHKSUM, ~(8'h01 << f_lane));
      fault(3'(c), 1'b0);
      if (c inside {3, 4})
        chk("irq_hold", 8'h00, {7'h0, irq_n});
      wr(OFS_CHKSUM, 8'h80);
      wr(OFS_INITSYNC, 8'h80);
      repeat (4) @(posedge mclk);
      chk("irq_clr", 8'h01, {7'h0, irq_n});
    end
    // threshold class routed to the sync request only with the enable set
    wr(OFS_TESTCTL, 8'h08);
    smask <= 3'b100;
    fault(3'd0, 1'b1);
    chk("sreq_thr", 8'h01, {7'h0, sreq});
    chk("err_lanes", 8'h01 << f_lane, eclr);
    fault(3'd0, 1'b0);
    chk("sreq_idle", 8'h00, {7'h0, sreq});
    chk("err_lanes_idle", 8'h00, eclr);
    close_out();
  end
endmodule : serial_link_irq_status_tb
